/* pinstrap_pkg.sv */
package pinstrap_pkg;
	// strap decoder: resistance arrives as a band index from the analogue front end (0 = lowest band)
	localparam int          BAND_W         = 5;
	localparam logic [4:0]  BAND_TRACK     = 5'h00;
	localparam logic [4:0]  BAND_ZERO      = 5'h11;
	// output voltage in millivolts
	localparam int          VOUT_W         = 13;
	localparam int          TEMP_W         = 12;
	localparam logic [11:0] OT_FAULT_RESET = 12'h0_073;
	localparam logic [11:0] OT_WARN_RESET  = 12'h0_069;
	localparam logic [11:0] TEMP_EXT_MIN   = 12'hF_D8;
	localparam logic [11:0] TEMP_EXT_MAX   = 12'h0_096;
	// gate drive in millivolts, 5.0 V to 8.5 V
	localparam logic [13:0] GATE_MIN       = 14'h1_388;
	localparam logic [13:0] GATE_MAX       = 14'h2_134;
	localparam logic [13:0] GATE_RESET     = 14'h1_388;
	localparam int          ADDR_PHASE_W   = 3;
	localparam int          PHASE_W        = 9;
	localparam int          CAL_NS         = 50000;
	localparam int          CLK_NS         = 5;
	localparam int          CAL_CYCLES     = CAL_NS / CLK_NS;
	typedef enum logic [2:0] {
		ST_BOOT  = 3'b000,
		ST_IDLE  = 3'b001,
		ST_CAL   = 3'b011,
		ST_SOFT  = 3'b010,
		ST_RUN   = 3'b110,
		ST_FAULT = 3'b111
	} run_state_t;
endpackage : pinstrap_pkg

/* strap_decoder.sv */
`timescale 1ns/100ps
module strap_decoder (
	input  wire logic [4:0]  band,
	input  wire logic [2:0]  addr_low,
	output logic             track,
	output logic [12:0]      vout_mv,
	output logic [8:0]       phase_deg
);
	always_comb begin
		track   = (band == pinstrap_pkg::BAND_TRACK);
		case (band)
			5'h01:   vout_mv = 13'h0_258;
			5'h02:   vout_mv = 13'h0_2BC;
			5'h03:   vout_mv = 13'h0_2EE;
			5'h04:   vout_mv = 13'h0_320;
			5'h05:   vout_mv = 13'h0_352;
			5'h06:   vout_mv = 13'h0_384;
			5'h07:   vout_mv = 13'h0_3B6;
			5'h08:   vout_mv = 13'h0_3E8;
			5'h09:   vout_mv = 13'h0_41A;
			5'h0A:   vout_mv = 13'h0_44C;
			5'h0B:   vout_mv = 13'h0_4B0;
			5'h0C:   vout_mv = 13'h0_5DC;
			5'h0D:   vout_mv = 13'h0_708;
			5'h0E:   vout_mv = 13'h0_9C4;
			5'h0F:   vout_mv = 13'h0_CE4;
			5'h10:   vout_mv = 13'h1_388;
			default: vout_mv = 13'h0_000; // track band and open strap both give zero
		endcase
		case (addr_low)
			3'h0:    phase_deg = 9'h0_00;
			3'h1:    phase_deg = 9'h0_3C;
			3'h2:    phase_deg = 9'h0_78;
			3'h3:    phase_deg = 9'h0_B4;
			3'h4:    phase_deg = 9'h0_F0;
			3'h5:    phase_deg = 9'h1_2C;
			3'h6:    phase_deg = 9'h0_5A;
			default: phase_deg = 9'h1_0E;
		endcase
	end
endmodule : strap_decoder

/* pinstrap_config_thermal_monitor.sv */
`timescale 1ns/100ps
module pinstrap_config_thermal_monitor #(
	parameter int CAL_COUNT = pinstrap_pkg::CAL_CYCLES
) (
	input  wire logic        REF_CLK,
	input  wire logic        RESETN,
	input  wire logic [4:0]  VSET_BAND,
	input  wire logic [2:0]  ADDR_LOW,
	input  wire logic        ENABLE,
	input  wire logic        CAL_CMD,
	input  wire logic        CAL_OK,
	input  wire logic        SOFT_DONE,
	input  wire logic        IN_REGULATION,
	input  wire logic [11:0] TEMP_INT,
	input  wire logic [11:0] TEMP_EXT,
	input  wire logic        REMOTE_DIODE_GROUNDED,
	input  wire logic [12:0] TRACKING_INPUT,
	input  wire logic        OT_FAULT_WR,
	input  wire logic        OT_WARN_WR,
	input  wire logic        GATE_WR,
	input  wire logic        PHASE_WR,
	input  wire logic        VOUT_WR,
	input  wire logic [13:0] HOST_DATA,
	input  wire logic        NV_STORE,
	input  wire logic        NV_VALID,
	input  wire logic [12:0] NV_VOUT,
	input  wire logic [8:0]  NV_PHASE,
	input  wire logic [11:0] NV_OT_FAULT,
	input  wire logic [11:0] NV_OT_WARN,
	input  wire logic [13:0] NV_GATE,
	input  wire logic        ALERT_CLEAR,
	output logic             NV_WRITE,
	output logic             TRACK_MODE,
	output logic [12:0]      VREF_MV,
	output logic [8:0]       PHASE_DEG,
	output logic [13:0]      GATE_DRIVE_MV,
	output logic [11:0]      OVERTEMP_FAULT_THRESHOLD,
	output logic [11:0]      OVERTEMP_WARN_THRESHOLD,
	output logic [11:0]      READ_TEMPERATURE_1,
	output logic [11:0]      READ_TEMPERATURE_2,
	output logic             OT_FAULT,
	output logic             CAL_ACTIVE,
	output logic             REGULATE,
	output logic             POWER_GOOD_OUTPUT_O,
	output logic             POWER_GOOD_OUTPUT_OE,
	output logic             ATTENTION_OUTPUT_O,
	output logic             ATTENTION_OUTPUT_OE
);
	logic                    rst_meta;
	logic                    rst_n;
	logic [1:0]              en_sync;
	logic [1:0]              sd_sync;
	logic [1:0]              diode_sync;
	logic                    en_prev;
	logic                    strapped;
	logic                    dec_track;
	logic [12:0]             dec_vout;
	logic [8:0]              dec_phase;
	logic [12:0]             vout_set;
	logic [31:0]             cal_cnt;
	logic                    alert;
	logic                    ext_ok;
	logic [11:0]             temp_used;
	pinstrap_pkg::run_state_t state;

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			en_sync    <= 2'b00;
			sd_sync    <= 2'b00;
			diode_sync <= 2'b11;
			en_prev    <= 1'b0;
		end else begin
			en_sync    <= {en_sync[0], ENABLE};
			sd_sync    <= {sd_sync[0], SOFT_DONE};
			diode_sync <= {diode_sync[0], REMOTE_DIODE_GROUNDED};
			en_prev    <= en_sync[1];
		end
	end

	strap_decoder u_dec (
		.band      (VSET_BAND),
		.addr_low  (ADDR_LOW),
		.track     (dec_track),
		.vout_mv   (dec_vout),
		.phase_deg (dec_phase)
	);

	// configuration: straps latched once, nonvolatile copy overrides all but the track strap, host writes after
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			strapped                 <= 1'b0;
			TRACK_MODE               <= 1'b0;
			vout_set                 <= '0;
			PHASE_DEG                <= '0;
			GATE_DRIVE_MV            <= pinstrap_pkg::GATE_RESET;
			OVERTEMP_FAULT_THRESHOLD <= pinstrap_pkg::OT_FAULT_RESET;
			OVERTEMP_WARN_THRESHOLD  <= pinstrap_pkg::OT_WARN_RESET;
		end else if (!strapped) begin
			strapped   <= 1'b1;
			TRACK_MODE <= dec_track;
			if (NV_VALID) begin
				vout_set                 <= NV_VOUT;
				PHASE_DEG                <= NV_PHASE;
				OVERTEMP_FAULT_THRESHOLD <= NV_OT_FAULT;
				OVERTEMP_WARN_THRESHOLD  <= NV_OT_WARN;
				GATE_DRIVE_MV            <= NV_GATE;
			end else begin
				vout_set  <= dec_vout;
				PHASE_DEG <= dec_phase;
			end
		end else begin
			if (OT_FAULT_WR)
				OVERTEMP_FAULT_THRESHOLD <= HOST_DATA[11:0];
			if (OT_WARN_WR)
				OVERTEMP_WARN_THRESHOLD <= HOST_DATA[11:0];
			if (VOUT_WR)
				vout_set <= HOST_DATA[12:0];
			// phase may only move while the output is off
			if (PHASE_WR && !REGULATE)
				PHASE_DEG <= HOST_DATA[8:0];
			if (GATE_WR) begin
				if (HOST_DATA < pinstrap_pkg::GATE_MIN)
					GATE_DRIVE_MV <= pinstrap_pkg::GATE_MIN;
				else if (HOST_DATA > pinstrap_pkg::GATE_MAX)
					GATE_DRIVE_MV <= pinstrap_pkg::GATE_MAX;
				else
					GATE_DRIVE_MV <= HOST_DATA;
			end
		end
	end

	// registered status outputs, all following their sources by one cycle
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			VREF_MV            <= '0;
			NV_WRITE           <= 1'b0;
			READ_TEMPERATURE_1 <= '0;
			READ_TEMPERATURE_2 <= '0;
		end else begin
			VREF_MV            <= TRACK_MODE ? TRACKING_INPUT : vout_set;
			NV_WRITE           <= NV_STORE && strapped;
			READ_TEMPERATURE_1 <= TEMP_INT;
			READ_TEMPERATURE_2 <= TEMP_EXT;
		end
	end

	// temperature selection; grounded diode or out-of-range reading falls back
	always_comb begin
		ext_ok    = !diode_sync[1] && ($signed(TEMP_EXT) >= $signed(pinstrap_pkg::TEMP_EXT_MIN))
		            && ($signed(TEMP_EXT) <= $signed(pinstrap_pkg::TEMP_EXT_MAX));
		temp_used = ext_ok ? TEMP_EXT : TEMP_INT;
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n)
			OT_FAULT <= 1'b0;
		else if ($signed(temp_used) >= $signed(OVERTEMP_FAULT_THRESHOLD))
			OT_FAULT <= 1'b1;
		else if ($signed(temp_used) < $signed(OVERTEMP_WARN_THRESHOLD))
			OT_FAULT <= 1'b0;
	end

	// sequencer
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state   <= pinstrap_pkg::ST_BOOT;
			cal_cnt <= '0;
		end else begin
			case (state)
				pinstrap_pkg::ST_BOOT:
					if (strapped)
						state <= pinstrap_pkg::ST_IDLE;
				pinstrap_pkg::ST_IDLE: begin
					cal_cnt <= '0;
					if (OT_FAULT)
						state <= pinstrap_pkg::ST_FAULT;
					else if ((en_sync[1] && !en_prev) || CAL_CMD)
						state <= pinstrap_pkg::ST_CAL;
				end
				pinstrap_pkg::ST_CAL: begin
					cal_cnt <= cal_cnt + 32'd1;
					if (OT_FAULT)
						state <= pinstrap_pkg::ST_FAULT;
					else if (cal_cnt >= CAL_COUNT - 1)
						state <= (CAL_OK && en_sync[1]) ? pinstrap_pkg::ST_SOFT : pinstrap_pkg::ST_IDLE;
				end
				pinstrap_pkg::ST_SOFT:
					if (OT_FAULT)
						state <= pinstrap_pkg::ST_FAULT;
					else if (!en_sync[1])
						state <= pinstrap_pkg::ST_IDLE;
					else if (sd_sync[1])
						state <= pinstrap_pkg::ST_RUN;
				pinstrap_pkg::ST_RUN:
					if (OT_FAULT)
						state <= pinstrap_pkg::ST_FAULT;
					else if (!en_sync[1])
						state <= pinstrap_pkg::ST_IDLE;
					else if (CAL_CMD)
						state <= pinstrap_pkg::ST_CAL;
				pinstrap_pkg::ST_FAULT: begin
					cal_cnt <= '0;
					if (!OT_FAULT)
						state <= en_sync[1] ? pinstrap_pkg::ST_CAL : pinstrap_pkg::ST_IDLE;
				end
				default:
					state <= pinstrap_pkg::ST_BOOT;
			endcase
		end
	end

	assign CAL_ACTIVE = (state == pinstrap_pkg::ST_CAL);
	assign REGULATE   = (state == pinstrap_pkg::ST_SOFT) || (state == pinstrap_pkg::ST_RUN);

	// power-good: open drain, released high only in steady regulation
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n)
			POWER_GOOD_OUTPUT_OE <= 1'b1;
		else
			POWER_GOOD_OUTPUT_OE <= !((state == pinstrap_pkg::ST_RUN) && IN_REGULATION && !OT_FAULT);
	end
	assign POWER_GOOD_OUTPUT_O = 1'b0;

	// alert is sticky: a new fault in the clear cycle wins
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n)
			alert <= 1'b0;
		else if (OT_FAULT || (state == pinstrap_pkg::ST_CAL && cal_cnt >= CAL_COUNT - 1 && !CAL_OK))
			alert <= 1'b1;
		else if (ALERT_CLEAR)
			alert <= 1'b0;
	end
	assign ATTENTION_OUTPUT_O  = 1'b0;
	assign ATTENTION_OUTPUT_OE = alert;

	straps_once_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		$past(strapped) |-> $stable(TRACK_MODE)) else $error("strap result changed");
	fault_set_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		$signed(temp_used) >= $signed(OVERTEMP_FAULT_THRESHOLD) |=> OT_FAULT) else $error("fault missed");
	fault_hold_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		OT_FAULT && $signed(temp_used) >= $signed(OVERTEMP_WARN_THRESHOLD) |=> OT_FAULT)
		else $error("fault cleared early");
	fault_stop_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		OT_FAULT |-> ##2 (POWER_GOOD_OUTPUT_OE && !REGULATE)) else $error("fault kept regulating");
	restart_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		state == pinstrap_pkg::ST_FAULT && !OT_FAULT && en_sync[1] |=> CAL_ACTIVE)
		else $error("no restart");
	temp_sel_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		diode_sync[1] |-> temp_used == TEMP_INT) else $error("grounded diode used");
	gate_range_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		$past(GATE_WR) && strapped && $past(strapped) |-> GATE_DRIVE_MV >= pinstrap_pkg::GATE_MIN
		&& GATE_DRIVE_MV <= pinstrap_pkg::GATE_MAX) else $error("gate out of range");
	pg_release_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		!POWER_GOOD_OUTPUT_OE |-> $past(state == pinstrap_pkg::ST_RUN && IN_REGULATION))
		else $error("power-good early");
	track_ref_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		TRACK_MODE && $past(TRACK_MODE) |-> VREF_MV == $past(TRACKING_INPUT))
		else $error("tracking ignored");
	alert_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		OT_FAULT |=> ATTENTION_OUTPUT_OE) else $error("alert missing");
	cal_on_en_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
		state == pinstrap_pkg::ST_IDLE && en_sync[1] && !en_prev && !OT_FAULT |=> CAL_ACTIVE)
		else $error("enable without calibration");
	run_c: cover property (@(posedge REF_CLK) disable iff (!rst_n) state == pinstrap_pkg::ST_RUN);
	fault_c: cover property (@(posedge REF_CLK) disable iff (!rst_n) state == pinstrap_pkg::ST_FAULT);
	recal_c: cover property (@(posedge REF_CLK) disable iff (!rst_n)
		state == pinstrap_pkg::ST_RUN && CAL_CMD);
endmodule : pinstrap_config_thermal_monitor

/* host_model.sv */
`timescale 1ns/100ps
module host_model (
	input  wire logic        clk,
	output logic [6:0]       wr,
	output logic [13:0]      data
);
	// wr bits: fault, warn, gate, phase, vout, calibrate, store
	initial begin
		wr = 7'h00;
		data = 14'h0000;
	end
	// one-cycle request; data is scrambled afterwards so nothing relies on a held value
	task automatic pulse(input logic [6:0] w, input logic [13:0] d);
		@(posedge clk);
		wr <= w;
		data <= d;
		@(posedge clk);
		wr <= 7'h00;
		data <= ~d;
	endtask : pulse
	// the task writes the fault level first when it is above 12'h069, otherwise the warning level first
	task automatic set_limits(input logic [11:0] fault, input logic [11:0] warn);
		if (fault > 12'h069) begin
			pulse(7'h01, {2'b00, fault});
			pulse(7'h02, {2'b00, warn});
		end else begin
			pulse(7'h02, {2'b00, warn});
			pulse(7'h01, {2'b00, fault});
		end
	endtask : set_limits
endmodule : host_model

/* pinstrap_config_thermal_monitor_tb_top.sv */
`timescale 1ns/100ps
module pinstrap_config_thermal_monitor_tb_top;
	logic        ref_clk   = 1'b0;
	logic        resetn    = 1'b0;
	logic [4:0]  band      = 5'h10;
	logic [2:0]  addr_low  = 3'h6;
	logic        enable    = 1'b0;
	logic        soft_done = 1'b0;
	logic        in_reg    = 1'b0;
	logic [11:0] temp_int  = 12'h01E;
	logic [11:0] temp_ext  = 12'h01E;
	logic        diode_gnd = 1'b0;
	logic        cal_ok    = 1'b1;
	logic        nv_valid  = 1'b0;
	logic        alert_clr = 1'b0;
	logic [12:0] track_in  = 13'h0320;
	logic [6:0]  wr;
	logic [13:0] host_data;
	logic [12:0] vref;
	logic [8:0]  phase;
	logic [13:0] gate;
	logic [11:0] fth, wth, t1, t2;
	logic        track, ot, cal_act, regulate, pg_oe, nv_write;
	logic        pg_o, alert_o, alert_oe;
	int          n_fail     = 0;
	int          n_compared = 0;

	always #2.5 ref_clk = ~ref_clk;

	host_model host (.clk(ref_clk), .wr(wr), .data(host_data));

	pinstrap_config_thermal_monitor #(.CAL_COUNT(8)) dut (
		.REF_CLK(ref_clk), .RESETN(resetn), .VSET_BAND(band), .ADDR_LOW(addr_low),
		.ENABLE(enable), .CAL_CMD(wr[5]), .CAL_OK(cal_ok), .SOFT_DONE(soft_done),
		.IN_REGULATION(in_reg), .TEMP_INT(temp_int), .TEMP_EXT(temp_ext),
		.REMOTE_DIODE_GROUNDED(diode_gnd), .TRACKING_INPUT(track_in),
		.OT_FAULT_WR(wr[0]), .OT_WARN_WR(wr[1]), .GATE_WR(wr[2]), .PHASE_WR(wr[3]),
		.VOUT_WR(wr[4]), .HOST_DATA(host_data), .NV_STORE(wr[6]), .NV_VALID(nv_valid),
		.NV_VOUT(13'h04B0), .NV_PHASE(9'h10E), .NV_OT_FAULT(12'h050), .NV_OT_WARN(12'h046),
		.NV_GATE(14'h1F40), .ALERT_CLEAR(alert_clr), .NV_WRITE(nv_write), .TRACK_MODE(track),
		.VREF_MV(vref), .PHASE_DEG(phase), .GATE_DRIVE_MV(gate),
		.OVERTEMP_FAULT_THRESHOLD(fth), .OVERTEMP_WARN_THRESHOLD(wth),
		.READ_TEMPERATURE_1(t1), .READ_TEMPERATURE_2(t2), .OT_FAULT(ot),
		.CAL_ACTIVE(cal_act), .REGULATE(regulate), .POWER_GOOD_OUTPUT_O(pg_o),
		.POWER_GOOD_OUTPUT_OE(pg_oe), .ATTENTION_OUTPUT_O(alert_o), .ATTENTION_OUTPUT_OE(alert_oe)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic temps(input logic [11:0] ti, input logic [11:0] te);
		@(posedge ref_clk);
		temp_int <= ti;
		temp_ext <= te;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : temps

	task automatic t_power_up;
		check(fth, 12'h073);
		check(wth, 12'h069);
		check(vref, 13'h1388);
		check(track, 1'b0);
		check(phase, 9'h05A);
		check(pg_oe, 1'b1);
		check({pg_o, alert_o}, 2'b00);
		check(alert_oe, 1'b0);
		@(posedge ref_clk);
		band <= 5'h00;
		addr_low <= 3'h1;
		repeat (4) @(posedge ref_clk);
		#1;
		check({track, vref, phase}, {1'b0, 13'h1388, 9'h05A});
		$display("power-up test done");
	endtask : t_power_up

	task automatic t_host_writes;
		host.pulse(7'h04, 14'h2328);
		#1;
		check(gate, 14'h2134);
		host.pulse(7'h04, 14'h0FA0);
		#1;
		check(gate, 14'h1388);
		host.pulse(7'h04, 14'h1B58);
		#1;
		check(gate, 14'h1B58);
		host.pulse(7'h10, 14'h04B0);
		@(posedge ref_clk);
		#1;
		check(vref, 13'h04B0);
		host.pulse(7'h08, 14'h00B4);
		#1;
		check(phase, 9'h0B4);
		host.set_limits(12'h064, 12'h05A);
		#1;
		check({fth, wth}, {12'h064, 12'h05A});
		host.set_limits(12'h073, 12'h069);
		temps(12'h02D, 12'h037);
		check({t1, t2}, {12'h02D, 12'h037});
		$display("host write test done");
	endtask : t_host_writes

	task automatic t_run_and_fault;
		@(posedge ref_clk);
		enable <= 1'b1;
		for (int i = 0; i < 10 && cal_act !== 1'b1; i++) @(posedge ref_clk);
		check(cal_act, 1'b1);
		for (int i = 0; i < 30 && regulate !== 1'b1; i++) @(posedge ref_clk);
		#1;
		check({regulate, pg_oe}, 2'b11);
		@(posedge ref_clk);
		soft_done <= 1'b1;
		in_reg <= 1'b1;
		for (int i = 0; i < 10 && pg_oe !== 1'b0; i++) @(posedge ref_clk);
		#1;
		check(pg_oe, 1'b0);
		host.pulse(7'h08, 14'h0000);
		#1;
		check(phase, 9'h0B4);
		temps(12'h01E, 12'h078);
		check({ot, regulate, pg_oe}, 3'b101);
		check(alert_oe, 1'b1);
		temps(12'h01E, 12'h06E);
		check(ot, 1'b1);
		temps(12'h01E, 12'h064);
		check(ot, 1'b0);
		for (int i = 0; i < 10 && cal_act !== 1'b1; i++) @(posedge ref_clk);
		check(cal_act, 1'b1);
		@(posedge ref_clk);
		alert_clr <= 1'b1;
		@(posedge ref_clk);
		alert_clr <= 1'b0;
		#1;
		check(alert_oe, 1'b0);
		// the command is only sent once the restart has settled back into regulation
		for (int i = 0; i < 20 && pg_oe !== 1'b0; i++) @(posedge ref_clk);
		#1;
		check(pg_oe, 1'b0);
		host.pulse(7'h20, 14'h0000);
		#1;
		check(cal_act, 1'b1);
		$display("run and fault test done");
	endtask : t_run_and_fault

	task automatic t_sensor_choice;
		temps(12'h01E, 12'h0C8);
		check(ot, 1'b0);
		temps(12'h078, 12'h0C8);
		check(ot, 1'b1);
		temps(12'h01E, 12'h01E);
		@(posedge ref_clk);
		diode_gnd <= 1'b1;
		// let the diode level pass its synchroniser before the hot reading arrives
		repeat (3) @(posedge ref_clk);
		temps(12'h01E, 12'h078);
		repeat (3) @(posedge ref_clk);
		check(ot, 1'b0);
		host.pulse(7'h40, 14'h0000);
		#1;
		check(nv_write, 1'b1);
		@(posedge ref_clk);
		#1;
		check(nv_write, 1'b0);
		for (int i = 0; i < 30 && pg_oe !== 1'b0; i++) @(posedge ref_clk);
		@(posedge ref_clk);
		alert_clr <= 1'b1;
		cal_ok <= 1'b0;
		@(posedge ref_clk);
		alert_clr <= 1'b0;
		#1;
		check(alert_oe, 1'b0);
		host.pulse(7'h20, 14'h0000);
		repeat (12) @(posedge ref_clk);
		#1;
		check({regulate, pg_oe, alert_oe}, 3'b011);
		@(posedge ref_clk);
		cal_ok <= 1'b1;
		$display("sensor choice test done");
	endtask : t_sensor_choice

	task automatic t_restart;
		@(posedge ref_clk);
		enable <= 1'b0;
		nv_valid <= 1'b1;
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (6) @(posedge ref_clk);
		#1;
		check(track, 1'b1);
		check(vref, 13'h0320);
		check({phase, gate}, {9'h10E, 14'h1F40});
		check({fth, wth}, {12'h050, 12'h046});
		@(posedge ref_clk);
		track_in <= 13'h0258;
		repeat (2) @(posedge ref_clk);
		#1;
		check(vref, 13'h0258);
		$display("restart test done");
	endtask : t_restart

	task automatic report_and_stop;
		$display("compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	// generous span: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		report_and_stop();
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (8) @(posedge ref_clk);
		#1;
		t_power_up();
		t_host_writes();
		t_run_and_fault();
		t_sensor_choice();
		t_restart();
		report_and_stop();
	end
endmodule : pinstrap_config_thermal_monitor_tb_top
